/* File: design/ncl_dev_end.sv */
// Configuration loader device: registers, store, burn, sequencing
// What this block does
// R1: Logic live once supply reset releases
// R2: Copy store to registers at power-up, after burn
// R3: Enable toggling never repeats the store copy
// R4: Checksum-checked load, else defaults plus error flag
// R5: Busy bit locks writes, reads still allowed
// R6: Host burns only with good supply, else aborts
// R7: Burn writes data plus 16-bit checksum
// R8: Busy clears after 100 ms wait
// R9: Regulators off during burn, resequence afterwards
// R10: Host reads store back to verify burn
// R11: Store burnable twice, readable over link
// R12: Register writes act immediately
// R13: Pairing bits sampled only at enable rise
// R14: Host sets pairing before raising enable
// R15: Paired channel follows first channel settings
// R16: Supply reset clears every working register
// R17: Over-temperature keeps register contents
// R18: Triple select sets feedback gain three
// R19: Voltage steps at slow or fast slew
// R20: Clamp bit limits reference to 1.830V
// R21: Soft start ramps reference after boost ready
// R22: Shifted half-duty sync clock after sequencing
// R23: One checksum function for burn and load
`timescale 1ns/10ps
`default_nettype none
module ncl_dev_end #(
  parameter int BURN_WAIT = ncl_pkg::BURN_WAIT_CYC
) (
  // Clock, reset, enable
  input  wire logic           MCLK,
  input  wire logic           SYS_RST,
  input  wire logic           CE,
  input  wire logic           NVM_BLANK,
  // Link to host
  ncl_link_if.dev             LINK,
  // Analog status
  input  wire logic           OVER_TEMP,
  input  wire logic           BOOST_READY,
  input  wire logic           ALL_SLEEP,
  // Regulator controls
  output logic [3:0]          BUCK_ON,
  output ncl_pkg::ncl_vref_t  VREF_CODE,
  output logic                FB_TRIPLE,
  output logic                OVP_EN,
  output logic                DISCH_EN,
  output logic [1:0]          PAIRING,
  output logic                SYNC_OUT_O,
  output logic                SYNC_OUT_OE,
  // Status
  output logic                CKSUM_ERR,
  output logic                NVM_BUSY
);
  import ncl_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    DS_LOAD, DS_RUN, DS_LOCK, DS_BURN, DS_WAIT
  } ncl_dst_t;

  typedef struct packed {
    ncl_dst_t              st;
    logic [7:0]            ctrl;
    logic [7:0]            ss;
    ncl_vref_t             vref;
    logic                  ckerr;
    logic [1:0]            par;
    logic [TMR_W-1:0]      tmr;
    logic [3:0]            on;
    ncl_vref_t             rf;
    logic [3:0][7:0]       rtmr;
    logic [3:0]            ssd;
    logic [2:0]            ls1;
    logic [2:0]            ls2;
    logic                  lclk_d;
    logic [4:0]            cnt;
    logic [15:0]           sh;
    logic [7:0]            rsh;
    logic                  miso;
    logic [3:0]            as1;
    logic [3:0]            as2;
    logic                  en_d;
    logic [3:0]            swc;
    logic                  swk;
    logic                  soe;
  } ncl_dev_s_t;

  ncl_dev_s_t             r_reg;
  ncl_dev_s_t             r_next;
  logic [7:0]             nvm [NVM_SIZE];
  logic [1:0]             burns_reg;
  logic                   nvm_we;
  logic [NVM_DATA*8-1:0]  ld;
  logic [NVM_DATA*8-1:0]  img;
  logic [15:0]            ck_img;
  logic                   match;
  logic                   rise;
  logic                   fall;
  logic                   wr;
  logic                   run_ok;
  logic [15:0]            nw;
  logic [TMR_W-1:0]       slot;

  // ==========================================================
  // Register read decode
  function automatic logic [7:0] rd(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == A_CTRL) begin
      v = r_reg.ctrl;
    end else if (a == A_STAT) begin
      v = {1'b0, burns_reg, &r_reg.ssd, |r_reg.on,
           r_reg.par, r_reg.ckerr};
    end else if (a == A_SS) begin
      v = r_reg.ss;
    end else if ((a & M_VREF) == A_VREF) begin
      v = r_reg.vref[a[1:0]];
    end else if ((a & M_NVM) == A_NVM) begin
      v = nvm[a[2:0]]; // R11
    end
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    int         src;
    logic [7:0] tgt;
    logic [7:0] step;
    src    = 0;
    tgt    = 8'h00;
    step   = 8'h00;
    r_next = r_reg;
    nvm_we = 1'b0;
    for (int i = 0; i < NVM_DATA; i++) begin
      ld[8*i+:8] = nvm[i];
    end
    match  = ncl_cksum(ld) == {nvm[CK_HI], nvm[CK_LO]}; // R4 R23
    img    = {r_reg.ss, r_reg.vref, r_reg.ctrl & ~BUSY_MASK};
    ck_img = ncl_cksum(img); // R7 R23

    // Pin synchronisers
    r_next.ls1    = {LINK.lclk, LINK.frame, LINK.mosi};
    r_next.ls2    = r_reg.ls1;
    r_next.lclk_d = r_reg.ls2[2];
    r_next.as1    = {LINK.enable_sync_input, OVER_TEMP,
                     BOOST_READY, ALL_SLEEP};
    r_next.as2    = r_reg.as1;
    r_next.en_d   = r_reg.as2[3];
    rise = r_reg.ls2[2] & ~r_reg.lclk_d;
    fall = ~r_reg.ls2[2] & r_reg.lclk_d;
    nw   = {r_reg.sh[14:0], r_reg.ls2[0]};
    wr   = 1'b0;

    // Link receiver and read shifter
    if (!r_reg.ls2[1]) begin
      r_next.cnt  = 5'h00;
      r_next.miso = 1'b0;
    end else if (rise) begin
      r_next.sh  = nw;
      r_next.cnt = r_reg.cnt + 5'h01;
      if (r_reg.cnt == HDR_LAST && nw[7]) begin
        r_next.rsh = rd(nw[6:0]); // R5
      end
      wr = (r_reg.cnt == FRAME_LAST) && !nw[15];
    end else if (fall && r_reg.cnt >= HDR_BITS) begin
      r_next.miso = r_reg.rsh[7];
      r_next.rsh  = {r_reg.rsh[6:0], 1'b0};
    end

    // Register writes
    if (wr && r_reg.st == DS_LOCK) begin
      if (nw[14:8] == A_BURN && nw[BURN_GO]) begin
        r_next.st = DS_BURN;
      end else if (nw[14:8] == A_BURN) begin
        r_next.st = DS_RUN; // R6
        r_next.ctrl[B_BUSY] = 1'b0;
      end
    end else if (wr && r_reg.st == DS_RUN) begin
      if (nw[14:8] == A_CTRL) begin
        r_next.ctrl = nw[7:0]; // R12
        if (nw[B_BUSY]) begin
          r_next.st = DS_LOCK; // R5
        end
      end else if (nw[14:8] == A_SS) begin
        r_next.ss = nw[7:0];
      end else if ((nw[14:8] & M_VREF) == A_VREF) begin
        r_next.vref[nw[9:8]] = nw[7:0]; // R12
      end
    end

    // Pairing latched at enable rise only
    if (r_reg.as2[3] && !r_reg.en_d) begin
      r_next.par = {r_reg.ctrl[B_PAR34], r_reg.ctrl[B_PAR12]}; // R13 R3
    end

    // Power-on sequencer, one channel per slot
    run_ok = r_reg.as2[3] && !r_reg.as2[2] &&
             (r_reg.st == DS_RUN || r_reg.st == DS_LOCK); // R9 R17
    slot = TMR_W'(r_reg.ss[3:0]) * TMR_W'(SLOT_CYC)
         + TMR_W'(SLOT_CYC);
    if (!run_ok) begin
      r_next.on = 4'h0;
      if (r_reg.st != DS_WAIT) begin
        r_next.tmr = '0;
      end
    end else if (r_reg.on != ALL_ON) begin
      if (r_reg.tmr >= slot - TMR_W'(1)) begin
        r_next.tmr = '0;
        r_next.on  = {r_reg.on[2:0], 1'b1}; // R9
      end else begin
        r_next.tmr = r_reg.tmr + TMR_W'(1);
      end
    end

    // Control sequence
    case (r_reg.st)
      DS_LOAD: begin
        r_next.tmr = '0;
        if (match) begin
          r_next.ctrl  = ld[7:0] & ~BUSY_MASK; // R2 R8
          r_next.vref  = ld[8*N_VREF+:32];
          r_next.ss    = ld[8*N_SS+:8];
          r_next.ckerr = 1'b0;
        end else begin
          r_next.ctrl  = DEF_CTRL; // R4
          r_next.vref  = {4{DEF_VREF}};
          r_next.ss    = DEF_SS;
          r_next.ckerr = 1'b1;
        end
        r_next.st = DS_RUN;
      end
      DS_BURN: begin
        nvm_we     = burns_reg < NVM_MAX_BURNS; // R11
        r_next.tmr = '0;
        r_next.st  = DS_WAIT;
      end
      DS_WAIT: begin
        if (r_reg.tmr == TMR_W'(BURN_WAIT - 1)) begin
          r_next.st = DS_LOAD; // R8 R2
        end else begin
          r_next.tmr = r_reg.tmr + TMR_W'(1);
        end
      end
      default: begin
      end
    endcase

    // Reference ramp per channel
    for (int i = 0; i < 4; i++) begin
      src = i;
      if ((i == 1 && r_reg.par[0]) || (i == 3 && r_reg.par[1])) begin
        src = i - 1; // R15
      end
      tgt = r_reg.vref[src];
      if (r_reg.ctrl[B_CLAMP] && tgt > CLAMP_CODE) begin
        tgt = CLAMP_CODE; // R20
      end
      if (!r_reg.ssd[i]) begin
        step = 8'(r_reg.ss[7:4]) * SS_STEP_CYC + SS_STEP_CYC;
      end else if (src == 0 && r_reg.ctrl[B_TRIPLE]) begin
        step = SLEW_HI_CYC; // R19
      end else begin
        step = SLEW_LO_CYC; // R19
      end
      if (!r_reg.on[i]) begin
        r_next.rf[i]   = 8'h00;
        r_next.ssd[i]  = 1'b0;
        r_next.rtmr[i] = 8'h00;
      end else if (r_reg.as2[1]) begin
        if (r_reg.rf[i] == tgt) begin
          r_next.ssd[i]  = 1'b1; // R21
          r_next.rtmr[i] = 8'h00;
        end else if (r_reg.rtmr[i] >= step - 8'h01) begin
          r_next.rtmr[i] = 8'h00;
          r_next.rf[i] = (tgt > r_reg.rf[i]) ? r_reg.rf[i] + 8'h01
                                             : r_reg.rf[i] - 8'h01;
        end else begin
          r_next.rtmr[i] = r_reg.rtmr[i] + 8'h01;
        end
      end
    end

    // Sync clock out, pulled low while internal clock is high
    if (r_reg.swc == SW_HALF_LAST) begin
      r_next.swc = 4'h0;
      r_next.swk = ~r_reg.swk;
    end else begin
      r_next.swc = r_reg.swc + 4'h1;
    end
    r_next.soe = r_reg.ctrl[B_SYNC] && r_reg.on == ALL_ON &&
                 !r_reg.as2[0] && r_reg.swk; // R22
  end

  // ==========================================================
  // Registers; supply reset clears all working state
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r_reg <= '0; // R1 R16
    end else if (CE) begin
      r_reg <= r_next;
    end
  end

  // Store survives supply reset; blank only by factory strobe
  always_ff @(posedge MCLK) begin
    if (CE) begin
      if (NVM_BLANK) begin
        for (int i = 0; i < NVM_SIZE; i++) begin
          nvm[i] <= 8'h00;
        end
        burns_reg <= 2'h0;
      end else if (nvm_we) begin
        for (int i = 0; i < NVM_DATA; i++) begin
          nvm[i] <= img[8*i+:8]; // R7
        end
        nvm[CK_LO] <= ck_img[7:0];
        nvm[CK_HI] <= ck_img[15:8];
        burns_reg  <= burns_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign BUCK_ON     = r_reg.on;
  assign VREF_CODE   = r_reg.rf;
  assign FB_TRIPLE   = r_reg.ctrl[B_TRIPLE]; // R18
  assign OVP_EN      = r_reg.ctrl[B_OVP];
  assign DISCH_EN    = r_reg.ctrl[B_DISCH];
  assign PAIRING     = r_reg.par;
  assign SYNC_OUT_O  = 1'b0;
  assign SYNC_OUT_OE = r_reg.soe;
  assign CKSUM_ERR   = r_reg.ckerr;
  assign NVM_BUSY    = r_reg.ctrl[B_BUSY];
  assign LINK.miso   = r_reg.miso;

endmodule
`default_nettype wire

/* File: design/ncl_host_end.sv */
// Host controller: AHB-Lite registers driving the serial link
`timescale 1ns/10ps
`default_nettype none
module ncl_host_end (
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  // Programming supply good pin
  input  wire logic        PROG_SUPPLY_OK,
  // Link to device
  ncl_link_if.host         LINK
);
  import ncl_pkg::*;

  typedef struct packed {
    logic        rdy;
    logic        ap;
    logic [7:0]  aa;
    logic [31:0] hrdata;
    logic        busy;
    logic [15:0] tx;
    logic [7:0]  rx;
    logic [4:0]  bitn;
    logic [2:0]  div;
    logic        lclk;
    logic        frame;
    logic        mosi;
    logic        en;
    logic [1:0]  ps;
  } ncl_host_s_t;

  ncl_host_s_t r_reg;
  ncl_host_s_t r_next;

  // ==========================================================
  // Next state
  always_comb begin
    r_next     = r_reg;
    r_next.rdy = 1'b1;
    r_next.ps  = {r_reg.ps[0], PROG_SUPPLY_OK};
    r_next.ap  = 1'b0;

    // Address phase; read data prepared for the data phase
    if (HSEL && HREADY && HTRANS[1] && HSIZE == 3'h2) begin
      r_next.ap     = HWRITE;
      r_next.aa     = HADDR[7:0];
      r_next.hrdata = 32'h0000_0000;
      if (HADDR[7:0] == H_STAT) begin
        r_next.hrdata = {16'h0000, r_reg.rx, 4'h0,
                         r_reg.ps[1], 1'b0, r_reg.en, r_reg.busy};
      end else if (HADDR[7:0] == H_CTRL) begin
        r_next.hrdata = {31'h0000_0000, r_reg.en};
      end
    end

    // Data phase of a write
    if (r_reg.ap && !r_reg.busy) begin
      if (r_reg.aa == H_CMD) begin
        r_next.busy  = 1'b1;
        r_next.tx    = HWDATA[15:0];
        if (HWDATA[14:8] == A_BURN && !HWDATA[15]) begin
          r_next.tx[BURN_GO] = HWDATA[BURN_GO] & r_reg.ps[1]; // R6
        end
        r_next.frame = 1'b1;
        r_next.mosi  = HWDATA[15];
        r_next.bitn  = 5'h00;
        r_next.div   = 3'h0;
        r_next.lclk  = 1'b0;
      end else if (r_reg.aa == H_CTRL) begin
        r_next.en = HWDATA[0]; // R14
      end
    end

    // Link engine: shift on falls, sample on rises
    if (r_reg.busy) begin
      if (r_reg.div == LCLK_HALF_LAST) begin
        r_next.div = 3'h0;
        if (!r_reg.frame) begin
          r_next.busy = 1'b0;
        end else if (!r_reg.lclk) begin
          r_next.lclk = 1'b1;
          r_next.bitn = r_reg.bitn + 5'h01;
          if (r_reg.bitn >= HDR_BITS) begin
            r_next.rx = {r_reg.rx[6:0], LINK.miso}; // R10
          end
        end else begin
          r_next.lclk = 1'b0;
          if (r_reg.bitn == FRAME_BITS) begin
            r_next.frame = 1'b0;
            r_next.mosi  = 1'b0;
          end else begin
            r_next.tx   = {r_reg.tx[14:0], 1'b0};
            r_next.mosi = r_reg.tx[14];
          end
        end
      end else begin
        r_next.div = r_reg.div + 3'h1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r_reg <= '0;
    end else if (CE) begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign HREADYOUT              = r_reg.rdy;
  assign HRDATA                 = r_reg.hrdata;
  assign HRESP                  = 1'b0;
  assign LINK.lclk              = r_reg.lclk;
  assign LINK.frame             = r_reg.frame;
  assign LINK.mosi              = r_reg.mosi;
  assign LINK.enable_sync_input = r_reg.en;

endmodule
`default_nettype wire

/* File: design/ncl_link_if.sv */
// Serial register link between host controller and loader device
`timescale 1ns/10ps
`default_nettype none
interface ncl_link_if;
  logic lclk;
  logic frame;
  logic mosi;
  logic miso;
  logic enable_sync_input;
  modport dev (input lclk, frame, mosi, enable_sync_input,
               output miso);
  modport host (output lclk, frame, mosi, enable_sync_input,
                input miso);
endinterface
`default_nettype wire

/* File: design/ncl_pkg.sv */
// Shared constants, types and checksum for the configuration loader link
package ncl_pkg;

  // ==========================================================
  // Clocks and timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int BURN_WAIT_MS  = 100;
  localparam int BURN_WAIT_CYC = BURN_WAIT_MS * (CLK_HZ / 1000);
  localparam int TMR_W         = 20;
  localparam int SLOT_CYC      = 1000;
  localparam logic [7:0] SS_STEP_CYC = 8'h0A;
  localparam int VREF_LSB_UV   = 10_000;
  localparam int SLEW_LO_NVUS  = 2600;
  localparam int SLEW_HI_NVUS  = 7800;
  localparam logic [7:0] SLEW_LO_CYC =
    8'(VREF_LSB_UV * CLK_MHZ / SLEW_LO_NVUS);
  localparam logic [7:0] SLEW_HI_CYC =
    8'(VREF_LSB_UV * CLK_MHZ / SLEW_HI_NVUS);
  localparam logic [3:0] SW_HALF_LAST = 4'h5;
  localparam logic [2:0] LCLK_HALF_LAST = 3'h7;

  // ==========================================================
  // Reference codes
  localparam int VREF_MIN_MV = 550;
  localparam int VREF_LSB_MV = 10;
  localparam int CLAMP_MV    = 1830;
  localparam logic [7:0] CLAMP_CODE =
    8'((CLAMP_MV - VREF_MIN_MV) / VREF_LSB_MV);
  typedef logic [3:0][7:0] ncl_vref_t;

  // ==========================================================
  // Device register map and fields
  localparam logic [6:0] A_CTRL = 7'h00;
  localparam logic [6:0] A_STAT = 7'h01;
  localparam logic [6:0] A_SS   = 7'h02;
  localparam logic [6:0] A_BURN = 7'h03;
  localparam logic [6:0] A_VREF = 7'h04;
  localparam logic [6:0] M_VREF = 7'h7C;
  localparam logic [6:0] A_NVM  = 7'h08;
  localparam logic [6:0] M_NVM  = 7'h78;
  localparam int B_BUSY   = 0;
  localparam int B_TRIPLE = 1;
  localparam int B_CLAMP  = 2;
  localparam int B_OVP    = 3;
  localparam int B_DISCH  = 4;
  localparam int B_PAR12  = 5;
  localparam int B_PAR34  = 6;
  localparam int B_SYNC   = 7;
  localparam int BURN_GO  = 0;
  localparam logic [7:0] BUSY_MASK = 8'h01;
  localparam logic [7:0] DEF_CTRL  = 8'h18;
  localparam logic [7:0] DEF_VREF  = 8'h2D;
  localparam logic [7:0] DEF_SS    = 8'h21;
  localparam logic [3:0] ALL_ON    = 4'hF;

  // ==========================================================
  // Nonvolatile store image
  localparam int NVM_DATA = 6;
  localparam int NVM_SIZE = 8;
  localparam int N_VREF   = 1;
  localparam int N_SS     = 5;
  localparam int CK_LO    = 6;
  localparam int CK_HI    = 7;
  localparam logic [1:0] NVM_MAX_BURNS = 2'h2;
  localparam logic [15:0] CKSUM_SEED   = 16'h5A5A;

  // ==========================================================
  // Link framing
  localparam logic [4:0] HDR_LAST   = 5'h07;
  localparam logic [4:0] HDR_BITS   = 5'h08;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // ==========================================================
  // Host register map
  localparam logic [7:0] H_CMD  = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam logic [7:0] H_CTRL = 8'h08;

  // Rotate-and-add, same for burn and load
  function automatic logic [15:0] ncl_cksum(
    input logic [NVM_DATA*8-1:0] d);
    logic [15:0] c;
    c = CKSUM_SEED;
    for (int i = 0; i < NVM_DATA; i++) begin
      c = {c[14:0], c[15]} + {8'h00, d[8*i+:8]};
    end
    return c;
  endfunction

endpackage

/* File: tb/ncl_link_sva.sv */
// Checker for the serial link joining the host and device ends
`timescale 1ns/10ps
`default_nettype none
module ncl_link_sva (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       SYS_RST,
  // Link
  input wire logic       lclk,
  input wire logic       frame,
  input wire logic       mosi,
  input wire logic       miso,
  input wire logic       enable_sync_input,
  // Device status
  input wire logic [3:0] BUCK_ON,
  input wire logic [1:0] PAIRING,
  input wire logic       NVM_BUSY,
  input wire logic       CKSUM_ERR
);
  // ==========================================
  // Link clock rises within the current frame
  logic [4:0] rise_cnt;
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !frame) begin
      rise_cnt <= 5'h00;
    end else if ($rose(lclk)) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  property p_lclk_idle;
    !frame |-> !lclk;
  endproperty
  a_lclk_idle: assert property (p_lclk_idle)
    else $error("link clock high outside a frame");

  property p_lclk_half;
    $rose(lclk) |-> lclk [*8] ##1 !lclk;
  endproperty
  a_lclk_half: assert property (p_lclk_half)
    else $error("link clock high phase not eight cycles");

  property p_mosi_hold;
    lclk && $past(lclk) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while link clock high");

  property p_miso_idle;
    !frame && !$past(frame, 6) |-> !miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("device data not low between frames");

  property p_frame_bits;
    $fell(frame) |-> rise_cnt == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame did not carry sixteen bits");

  property p_frame_start;
    $rose(frame) |-> !lclk ##[1:10] lclk;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("first link clock rise missing after frame start");

  property p_reset_clear;
    $past(SYS_RST) |-> BUCK_ON == 4'h0 && !NVM_BUSY && !CKSUM_ERR
      && PAIRING == 2'h0 && !miso;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("device state not cleared by reset");

  property p_en_idle;
    $changed(enable_sync_input) |-> !frame;
  endproperty
  a_en_idle: assert property (p_en_idle)
    else $error("enable changed during a frame");

  property p_pair_hold;
    enable_sync_input && $past(enable_sync_input, 6) |-> $stable(PAIRING);
  endproperty
  a_pair_hold: assert property (p_pair_hold)
    else $error("pairing changed while enabled");
endmodule
`default_nettype wire

/* File: tb/test_nvm_config_loader.sv */
// Testbench: host and device ends joined over the serial link
`timescale 1ns/10ps
`default_nettype none
module test_nvm_config_loader;
  import ncl_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        nvm_blank = 1'b1;
  logic        over_temp = 1'b0;
  logic        all_sleep = 1'b0;
  logic        prog_ok = 1'b1;
  logic        boost_rdy = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [3:0]  buck_on;
  ncl_vref_t   vref;
  logic [1:0]  pairing;
  logic        fb_tri, ovp_en, dis_en, sync_o, sync_oe, ck_err, busy;
  logic [7:0]  v_exp;
  logic [7:0]  nv [8];
  logic [15:0] c;
  int          waited;
  int          k;
  int          miscompares = 0;
  int          samples_checked = 0;

  ncl_link_if lnk ();
  always #50 mclk = ~mclk;

  ncl_dev_end #(.BURN_WAIT(200)) u_ncl_dev_end (
    .MCLK(mclk), .SYS_RST(sys_rst), .CE(1'b1), .NVM_BLANK(nvm_blank),
    .LINK(lnk), .OVER_TEMP(over_temp), .BOOST_READY(boost_rdy),
    .ALL_SLEEP(all_sleep), .BUCK_ON(buck_on), .VREF_CODE(vref),
    .FB_TRIPLE(fb_tri), .OVP_EN(ovp_en), .DISCH_EN(dis_en),
    .PAIRING(pairing), .SYNC_OUT_O(sync_o), .SYNC_OUT_OE(sync_oe),
    .CKSUM_ERR(ck_err), .NVM_BUSY(busy));
  ncl_host_end u_ncl_host_end (
    .MCLK(mclk), .SYS_RST(sys_rst), .CE(1'b1), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(), .PROG_SUPPLY_OK(prog_ok), .LINK(lnk));
  ncl_link_sva u_ncl_link_sva (
    .MCLK(mclk), .SYS_RST(sys_rst), .lclk(lnk.lclk), .frame(lnk.frame),
    .mosi(lnk.mosi), .miso(lnk.miso),
    .enable_sync_input(lnk.enable_sync_input), .BUCK_ON(buck_on),
    .PAIRING(pairing), .NVM_BUSY(busy), .CKSUM_ERR(ck_err));

  // ==========================================
  // Checking and bounded waits
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: return hready === 1'b1;
      1: return vref[0] === v_exp;
      2: return busy === 1'b0;
      default: return buck_on === ALL_ON;
    endcase
  endfunction
  task automatic await(input int sel, input int lim);
    waited = 0;
    do begin
      @(negedge mclk);
      waited++;
    end while (!cond(sel) && waited < lim);
    if (!cond(sel)) begin
      miscompares++;
      summarize();
    end
  endtask

  // ==========================================
  // Bus and device access
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    await(0, 20);
    @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    await(0, 20);
    rd = hrdata;
  endtask
  task automatic dev(input logic r, input logic [6:0] a,
                     input logic [7:0] d);
    int n;
    ahb(1'b1, H_CMD, {16'h0, r, a, d});
    repeat (2) @(posedge mclk);
    n = 0;
    do begin
      ahb(1'b0, H_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic burn(input logic ok, input logic [1:0] used);
    @(posedge mclk);
    prog_ok <= ok;
    dev(1'b0, A_CTRL, 8'h03);
    chk(busy, 1'b1);
    dev(1'b0, A_VREF, 8'h10);
    dev(1'b1, A_VREF, 8'h00);
    chk(rd[15:8], 8'hFF);
    dev(1'b0, A_BURN, 8'h01);
    chk(buck_on, ok ? 4'h0 : ALL_ON);
    await(2, 5000);
    chk(ck_err, !ok);
    await(3, 30000);
    dev(1'b1, A_STAT, 8'h00);
    chk(rd[14:13], used);
  endtask
  task automatic oe_count();
    k = 0;
    repeat (24) begin
      @(negedge mclk);
      k += sync_oe;
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    nvm_blank <= 1'b0;
    await(0, 20);
    repeat (3) @(posedge mclk);
    chk({ck_err, ovp_en, dis_en}, 3'h7);
    dev(1'b1, A_SS, 8'h00);
    chk(rd[15:8], DEF_SS);
    dev(1'b0, A_CTRL, 8'h1A);
    chk({fb_tri, ovp_en, dis_en}, 3'h7);
    dev(1'b0, A_CTRL, 8'h24);
    chk({fb_tri, ovp_en, dis_en}, 3'h0);
    ahb(1'b1, H_CTRL, 32'h1);
    repeat (2100) @(posedge mclk);
    chk({buck_on[0], vref[0]}, 9'h100);
    boost_rdy <= 1'b1;
    v_exp = DEF_VREF;
    await(1, 30000);
    chk(pairing, 2'h1);
    await(3, 30000);
    dev(1'b0, A_CTRL, 8'h04);
    dev(1'b0, A_VREF, 8'hFF);
    chk(pairing, 2'h1);
    v_exp = DEF_VREF + 8'h03;
    await(1, 300);
    v_exp = DEF_VREF + 8'h04;
    await(1, 300);
    chk(waited, SLEW_LO_CYC);
    v_exp = CLAMP_CODE;
    await(1, 5000);
    repeat (100) @(posedge mclk);
    chk({vref[0], vref[1]}, {CLAMP_CODE, CLAMP_CODE});
    dev(1'b0, A_CTRL, 8'h02);
    v_exp = CLAMP_CODE + 8'h03;
    await(1, 300);
    v_exp = CLAMP_CODE + 8'h04;
    await(1, 300);
    chk(waited, SLEW_HI_CYC);
    ahb(1'b1, H_CTRL, 32'h0);
    repeat (50) @(posedge mclk);
    ahb(1'b1, H_CTRL, 32'h1);
    await(3, 30000);
    dev(1'b1, A_VREF, 8'h00);
    chk({rd[15:8], 6'h00, pairing}, 16'hFF00);
    @(posedge mclk);
    over_temp <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(buck_on, 4'h0);
    over_temp <= 1'b0;
    dev(1'b1, A_VREF, 8'h00);
    chk(rd[15:8], 8'hFF);
    await(3, 30000);
    burn(1'b0, 2'h0);
    for (int i = 1; i <= 3; i++) begin
      burn(1'b1, (i > 2) ? 2'h2 : 2'(i));
    end
    for (int i = 0; i < NVM_SIZE; i++) begin
      dev(1'b1, A_NVM + 7'(i), 8'h00);
      nv[i] = rd[15:8];
    end
    c = CKSUM_SEED;
    for (int i = 0; i < NVM_DATA; i++) begin
      c = {c[14:0], c[15]} + {8'h00, nv[i]};
    end
    chk({nv[7], nv[6]}, c);
    chk({nv[1], nv[5]}, {8'hFF, DEF_SS});
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    await(0, 20);
    repeat (3) @(posedge mclk);
    chk({ck_err, buck_on, pairing}, 7'h00);
    dev(1'b1, A_VREF, 8'h00);
    chk(rd[15:8], 8'hFF);
    dev(1'b0, A_CTRL, 8'h80);
    ahb(1'b1, H_CTRL, 32'h1);
    await(3, 30000);
    oe_count();
    chk(k, 12);
    chk(sync_o, 1'b0);
    @(posedge mclk);
    all_sleep <= 1'b1;
    repeat (5) @(posedge mclk);
    oe_count();
    chk(k, 0);
    summarize();
  end
endmodule
`default_nettype wire
